// >>> src/ocss_top.sv
// Oscillator clock source control: AHB-Lite registers, internal
// oscillator model, output clock generation and second-pin routing.
// Assumes one 50 MHz hclk; pin buffers and analog cells sit outside.
`include "ocss_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module ocss_top
    import ocss_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // System integration controls
    input  wire logic        sys_osc_enable,
    input  wire logic        stop_mode,
    // First oscillator pin
    input  wire logic        clk_in_pin,
    output logic             clk_in_is_clock,
    // Second oscillator pin
    input  wire logic        clk_out_pin_i,
    output logic             clk_out_pin_o,
    output logic             clk_out_pin_oe,
    // Port bit 4 user side
    input  wire logic        port_a_bit4_out,
    input  wire logic        port_a_bit4_dir,
    output logic             port_a_bit4_in,
    // Generated clocks
    output logic             clk_times_four,
    output logic             clk_times_two,
    output logic             internal_osc_clk
);

    ocss_sw_if sw ();

    ocss_switch ocss_switch_inst (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .clk_in_pin (clk_in_pin),
        .sw         (sw.sw)
    );

    // ---- Bus data phase tracking ----
    logic       dp_wr;
    logic       dp_rd;
    logic       rd_done;
    logic [7:0] dp_addr;

    wire logic acc = hsel & hready & htrans[1];

    // One wait state on reads so a preceding write is visible
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr   <= 1'b0;
            dp_rd   <= 1'b0;
            rd_done <= 1'b0;
            dp_addr <= 8'h00;
        end else begin
            dp_wr   <= acc & hwrite;
            rd_done <= dp_rd & ~rd_done;
            if (acc & ~hwrite)
                dp_rd <= 1'b1;
            else if (rd_done)
                dp_rd <= 1'b0;
            if (acc)
                dp_addr <= haddr[7:0];
        end
    end

    assign hreadyout = ~(dp_rd & ~rd_done);
    assign hresp     = 1'b0;

    // ---- Register decode ----
    wire logic hit_stat = dp_addr == `OCSS_STATUS_OFS;
    wire logic hit_trim = dp_addr == `OCSS_TRIM_OFS;
    wire logic hit_cfg  = dp_addr == `OCSS_CONFIG_OFS;
    wire logic hit_pue  = dp_addr == `OCSS_PULLUP_OFS;

    wire logic wr_stat = dp_wr & hit_stat;
    wire logic wr_trim = dp_wr & hit_trim;
    wire logic wr_cfg  = dp_wr & hit_cfg;
    wire logic wr_pue  = dp_wr & hit_pue;

    // ---- Software registers ----
    logic       ext_gen_enable;
    logic [7:0] osc_trim_reg;
    logic [1:0] source_select;
    logic       clock_out_enable;

    // Trim resets to mid-scale; factory value is software's job
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_gen_enable   <= 1'b0;
            osc_trim_reg     <= `OCSS_TRIM_RST;
            source_select    <= `OCSS_SRC_INT;
            clock_out_enable <= 1'b0;
        end else begin
            if (wr_stat)
                ext_gen_enable <= hwdata[`OCSS_ECG_BIT];
            if (wr_trim)
                osc_trim_reg <= hwdata[7:0];
            if (wr_cfg)
                source_select <= hwdata[1:0];
            if (wr_pue)
                clock_out_enable <= hwdata[`OCSS_OUTEN_BIT];
        end
    end

    // ---- Read data ----
    logic [31:0] stat_word;
    logic [31:0] rd_mux;

    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[`OCSS_ECG_BIT]  = ext_gen_enable;
        stat_word[`OCSS_ENG_BIT]  = sw.engaged;
        stat_word[`OCSS_IRUN_BIT] = sw.int_run;
    end

    assign rd_mux = hit_stat ? stat_word :
                    hit_trim ? {24'h00_0000, osc_trim_reg} :
                    hit_cfg  ? {30'h0000_0000, source_select} :
                    hit_pue  ? {31'h0000_0000, clock_out_enable} :
                    32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (dp_rd & ~rd_done)
            hrdata <= rd_mux;
    end

    // ---- Mode decode ----
    wire logic mode_int  = source_select == `OCSS_SRC_INT;
    wire logic mode_ext  = source_select == `OCSS_SRC_EXT;
    wire logic mode_xtal = source_select == `OCSS_SRC_XTAL;

    // Oscillator enable and stop both gate the selected source
    wire logic osc_run = sys_osc_enable & ~stop_mode;

    assign sw.gen_req = ext_gen_enable;
    assign sw.ext_sel = ~mode_int;
    assign sw.int_clk = internal_osc_clk;

    assign clk_in_is_clock = ~mode_int;

    // ---- Internal oscillator ----
    // Phase accumulator: resolution is one hclk, so only the mean
    // period follows the trim; edges jitter by up to 20 ns.
    logic [15:0] osc_phase;

    wire logic [15:0] osc_inc =
        16'(`OCSS_INC_TOP - `OCSS_INC_STEP * {8'h00, osc_trim_reg});
    wire logic osc_go = osc_run & sw.int_run;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            osc_phase <= 16'h0000;
        else if (osc_go)
            osc_phase <= osc_phase + osc_inc;
        else
            osc_phase <= 16'h0000;
    end

    assign internal_osc_clk = osc_phase[15];

    // ---- Output clocks ----
    wire logic src_lvl  = sw.use_ext ? sw.ext_lvl : internal_osc_clk;
    wire logic next_x4  = osc_run & src_lvl;
    wire logic x4_rise  = next_x4 & ~clk_times_four;

    // Divider cleared while halted so both clocks rest low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_times_four <= 1'b0;
            clk_times_two  <= 1'b0;
        end else begin
            clk_times_four <= next_x4;
            if (!osc_run)
                clk_times_two <= 1'b0;
            else if (x4_rise)
                clk_times_two <= ~clk_times_two;
        end
    end

    // ---- Second pin routing ----
    // Enable bit only matters in internal or RC mode
    wire logic pin_is_clk = ~mode_ext & ~mode_xtal & clock_out_enable;
    wire logic next_pin_o = mode_xtal  ? ~sw.ext_lvl :
                            pin_is_clk ? clk_times_four :
                            port_a_bit4_out;
    wire logic next_pin_oe = mode_xtal | pin_is_clk | port_a_bit4_dir;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_out_pin_o  <= 1'b0;
            clk_out_pin_oe <= 1'b0;
        end else begin
            clk_out_pin_o  <= next_pin_o;
            clk_out_pin_oe <= next_pin_oe;
        end
    end

    // ---- Port bit 4 input ----
    logic pa_s1, pa_s2, pa_s3;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {pa_s1, pa_s2, pa_s3} <= 3'h0;
            port_a_bit4_in <= 1'b0;
        end else begin
            pa_s1 <= clk_out_pin_i;
            pa_s2 <= pa_s1;
            pa_s3 <= pa_s2;
            if (pa_s2 == pa_s3)
                port_a_bit4_in <= pa_s3;
        end
    end

    // ---- Checks ----
    chk_trim_period: assert property (@(posedge hclk) disable iff (!hresetn)
        osc_trim_reg > $past(osc_trim_reg) |-> osc_inc < $past(osc_inc))
        else $error("larger trim did not slow the oscillator");

    chk_gen_reset: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> !ext_gen_enable) else $error("enable bit set out of reset");

    chk_x2_follows: assert property (@(posedge hclk) disable iff (!hresetn)
        $changed(clk_times_two) && osc_run |-> $rose(clk_times_four))
        else $error("x2 changed without x4 rising");

    chk_stop_halts: assert property (@(posedge hclk) disable iff (!hresetn)
        stop_mode |=> !clk_times_four && !clk_times_two)
        else $error("clocks ran in stop mode");

    chk_osc_enable: assert property (@(posedge hclk) disable iff (!hresetn)
        !sys_osc_enable ##1 !sys_osc_enable |-> !clk_times_four && osc_phase == 16'h0000)
        else $error("source ran while disabled");

    chk_ext_port: assert property (@(posedge hclk) disable iff (!hresetn)
        mode_ext |=> clk_out_pin_oe == $past(port_a_bit4_dir)
                     && clk_out_pin_o == $past(port_a_bit4_out))
        else $error("external mode pin is not the port bit");

    chk_xtal_pin: assert property (@(posedge hclk) disable iff (!hresetn)
        mode_xtal |=> clk_out_pin_oe && clk_out_pin_o == !$past(sw.ext_lvl))
        else $error("crystal mode pin is not the amplifier output");

    chk_clk_out: assert property (@(posedge hclk) disable iff (!hresetn)
        pin_is_clk |=> clk_out_pin_oe && clk_out_pin_o == $past(clk_times_four))
        else $error("clock output not on second pin");

    chk_int_stops: assert property (@(posedge hclk) disable iff (!hresetn)
        !sw.int_run |=> !internal_osc_clk) else $error("internal clock after stop");

    chk_ext_input: assert property (@(posedge hclk) disable iff (!hresetn)
        !mode_int |-> clk_in_is_clock) else $error("first pin not clock input");

    chk_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
        acc && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read answer not after one wait state");

    // Bus side
    chk_write_fast: assert property (@(posedge hclk) disable iff (!hresetn)
        acc && hwrite |=> hreadyout)
        else $error("write answered with a wait state");

    chk_rdata_holds: assert property (@(posedge hclk) disable iff (!hresetn)
        !(dp_rd && !rd_done) |=> $stable(hrdata))
        else $error("read data moved outside a read");

    chk_unmapped_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        dp_rd && !rd_done && !(hit_stat || hit_trim || hit_cfg || hit_pue)
        |=> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    chk_trim_read: assert property (@(posedge hclk) disable iff (!hresetn)
        dp_rd && !rd_done && hit_trim |=> hrdata == {24'h00_0000, $past(osc_trim_reg)})
        else $error("trim read back wrong");

    chk_trim_store: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_trim |=> osc_trim_reg == $past(hwdata[7:0]))
        else $error("trim write lost");

    chk_trim_reset: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> osc_trim_reg == `OCSS_TRIM_RST)
        else $error("trim not mid-scale out of reset");

    chk_gen_store: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_stat |=> ext_gen_enable == $past(hwdata[`OCSS_ECG_BIT]))
        else $error("generator enable write lost");

    chk_cfg_store: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_cfg |=> source_select == $past(hwdata[1:0]))
        else $error("source select write lost");

    chk_cfg_reset: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> mode_int && !clock_out_enable)
        else $error("not internal source out of reset");

    chk_pue_store: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pue |=> clock_out_enable == $past(hwdata[`OCSS_OUTEN_BIT]))
        else $error("clock output enable write lost");

    // Clock and second pin side
    chk_int_restart: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> sw.int_run && !sw.engaged && !sw.use_ext)
        else $error("internal oscillator not running out of reset");

    chk_int_mode: assert property (@(posedge hclk) disable iff (!hresetn)
        mode_int |-> !clk_in_is_clock && !sw.ext_sel)
        else $error("first pin taken as clock in internal mode");

    chk_x4_int: assert property (@(posedge hclk) disable iff (!hresetn)
        osc_run && !sw.use_ext |=> clk_times_four == $past(internal_osc_clk))
        else $error("x4 does not follow internal clock");

    chk_x4_ext: assert property (@(posedge hclk) disable iff (!hresetn)
        osc_run && sw.use_ext |=> clk_times_four == $past(sw.ext_lvl))
        else $error("x4 does not follow external clock");

    chk_x2_halves: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(clk_times_four) |-> $changed(clk_times_two))
        else $error("x2 missed an x4 rise");

    chk_halt_phase: assert property (@(posedge hclk) disable iff (!hresetn)
        !osc_run |=> osc_phase == 16'h0000 && !clk_times_two)
        else $error("oscillator ran while halted");

    chk_port_pin: assert property (@(posedge hclk) disable iff (!hresetn)
        !mode_xtal && !pin_is_clk |=> clk_out_pin_oe == $past(port_a_bit4_dir)
                                      && clk_out_pin_o == $past(port_a_bit4_out))
        else $error("second pin is not the port bit");

    chk_pin_filter: assert property (@(posedge hclk) disable iff (!hresetn)
        $changed(port_a_bit4_in) |-> $past(pa_s2) == $past(pa_s3))
        else $error("port input changed before filter agreed");

endmodule
`default_nettype wire

// >>> src/ocss_consts.svh
// Offsets, fields, reset values and oscillator timing constants.
// Included by both design modules and the bench of the clock source switch.
`ifndef OCSS_CONSTS_SVH
`define OCSS_CONSTS_SVH

`define OCSS_STATUS_OFS   8'h00
`define OCSS_TRIM_OFS     8'h04
`define OCSS_CONFIG_OFS   8'h08
`define OCSS_PULLUP_OFS   8'h0C

`define OCSS_ECG_BIT      0
`define OCSS_ENG_BIT      1
`define OCSS_IRUN_BIT     2
`define OCSS_OUTEN_BIT    0

`define OCSS_TRIM_RST     8'h80
`define OCSS_SRC_INT      2'h0
`define OCSS_SRC_EXT      2'h1
`define OCSS_SRC_RC       2'h2
`define OCSS_SRC_XTAL     2'h3

`define OCSS_INT_KHZ      12800
`define OCSS_HCLK_KHZ     50000
`define OCSS_INC_NOM      16'((`OCSS_INT_KHZ * 65536) / `OCSS_HCLK_KHZ)
`define OCSS_INC_STEP     16'h0022
`define OCSS_INC_TOP      (`OCSS_INC_NOM + `OCSS_INC_STEP * 16'h0080)

`endif

// >>> src/ocss_pkg.sv
// Types for the oscillator clock source switch.
// Numeric constants live in ocss_consts.svh.
package ocss_pkg;
    typedef enum logic [2:0] {
        sw_idle, sw_probe, sw_align, sw_flag, sw_done
    } ocss_sw_state_t;
endpackage

// >>> src/ocss_sw_if.sv
// Signals between the register side and the switch controller.
// Both ends run on hclk.
`timescale 1ns/100ps
`default_nettype none
interface ocss_sw_if;
    logic gen_req;
    logic ext_sel;
    logic int_clk;
    logic ext_lvl;
    logic use_ext;
    logic engaged;
    logic int_run;
    modport ctl (output gen_req, ext_sel, int_clk,
                 input  ext_lvl, use_ext, engaged, int_run);
    modport sw  (input  gen_req, ext_sel, int_clk,
                 output ext_lvl, use_ext, engaged, int_run);
endinterface
`default_nettype wire

// >>> src/ocss_switch.sv
// Internal-to-external changeover controller.
// Assumes clk_in_pin is asynchronous and at most about hclk/6.
`include "ocss_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module ocss_switch
    import ocss_pkg::*;
(
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // First oscillator pin
    input  wire logic clk_in_pin,
    // Register side
    ocss_sw_if.sw     sw
);
    logic           ext_s1, ext_s2, ext_s3, ext_lvl;
    logic           req_s1, req_s2;
    logic           use_ext, engaged, int_run;
    logic [1:0]     edges;
    ocss_sw_state_t state;

    // Level changes only once two later stages agree
    wire logic ext_rise = (ext_s2 == ext_s3) & ext_s3 & ~ext_lvl;
    wire logic both_low = ~sw.int_clk & ~ext_lvl;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {ext_s1, ext_s2, ext_s3, ext_lvl} <= 4'h0;
            {req_s1, req_s2} <= 2'h0;
        end else begin
            ext_s1 <= clk_in_pin;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
            if (ext_s2 == ext_s3)
                ext_lvl <= ext_s3;
            req_s1 <= sw.gen_req;
            req_s2 <= req_s1;
        end
    end

    // Once done, only reset leaves sw_done; no clock monitor exists
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state   <= sw_idle;
            edges   <= 2'h0;
            use_ext <= 1'b0;
            engaged <= 1'b0;
            int_run <= 1'b1;
        end else begin
            case (state)
                sw_idle: begin
                    edges <= 2'h0;
                    if (req_s2 & sw.ext_sel)
                        state <= sw_probe;
                end
                sw_probe: begin
                    if (!req_s2)
                        state <= sw_idle;
                    else if (ext_rise) begin
                        edges <= edges + 2'h1;
                        if (edges == 2'h1)
                            state <= sw_align;
                    end
                end
                sw_align: begin
                    // Both low: no shortened pulse at the mux
                    if (both_low) begin
                        use_ext <= 1'b1;
                        state   <= sw_flag;
                    end
                end
                sw_flag: begin
                    engaged <= 1'b1;
                    state   <= sw_done;
                end
                sw_done: int_run <= 1'b0;
                default: state <= sw_idle;
            endcase
        end
    end

    assign sw.ext_lvl = ext_lvl;
    assign sw.use_ext = use_ext;
    assign sw.engaged = engaged;
    assign sw.int_run = int_run;

    chk_two_edges: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(use_ext) |-> edges == 2'h2) else $error("switch before two edges");
    chk_glitch_free: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(use_ext) |-> !$past(sw.int_clk) && !$past(ext_lvl))
        else $error("switch while a clock was high");
    chk_engage_order: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(engaged) |-> int_run ##1 !int_run) else $error("engage order wrong");
    chk_no_return: assert property (@(posedge hclk) disable iff (!hresetn)
        engaged |=> engaged && use_ext && !int_run) else $error("fell back to internal");
endmodule
`default_nettype wire

// >>> verif/ocss_ext_src.sv
// Far-side clock source: stands in for an external clock, RC network or crystal.
// Assumes a half period of at least three hclk cycles so the pin filter sees each phase.
`timescale 1ns/100ps
`default_nettype none
module ocss_ext_src #(
    parameter int HALF_NS = 130
) (
    // Control from the bench
    input  wire logic run,
    // First oscillator pin
    output logic      clk_out
);
    // Stopped source holds its line low; start phase is unrelated to hclk
    always begin
        if (run !== 1'b1) begin
            clk_out = 1'b0;
            wait (run === 1'b1);
            #7;
        end
        #(HALF_NS);
        clk_out = ~clk_out;
    end
endmodule
`default_nettype wire

// >>> verif/osc_clock_source_switch_tb.sv
// Self-checking bench for ocss_top: AHB-Lite register tasks, clock counts, pin checks.
// Assumes ocss_ext_src drives the first pin and one 50 MHz hclk.
`include "ocss_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module osc_clock_source_switch_tb
    import ocss_pkg::*;
;
    localparam logic [31:0] S_ECG = 32'h0000_0001 << `OCSS_ECG_BIT;
    localparam logic [31:0] S_ENG = 32'h0000_0001 << `OCSS_ENG_BIT;
    localparam logic [31:0] S_RUN = 32'h0000_0001 << `OCSS_IRUN_BIT;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, v;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b010;
    logic        hreadyout, hresp, sys_osc_enable = 1'b1, stop_mode = 1'b0;
    logic        clk_in_pin, clk_in_is_clock, clk_out_pin_o, clk_out_pin_oe;
    logic        port_a_bit4_out = 1'b0, port_a_bit4_dir = 1'b0, port_a_bit4_in;
    logic        clk_times_four, clk_times_two, internal_osc_clk;
    logic        ext_run = 1'b0, pin_drv = 1'b0;
    wire logic   pin_lvl = clk_out_pin_oe ? clk_out_pin_o : pin_drv;
    int          n_errors = 0, total_checks = 0, cnt, k;
    int          tlo[3] = '{318, 254, 187};
    int          thi[3] = '{326, 258, 193};
    logic [7:0]  tval[3] = '{8'h00, 8'h80, 8'hFF};

    initial forever #10 hclk = ~hclk;

    ocss_top ocss_top_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .sys_osc_enable(sys_osc_enable), .stop_mode(stop_mode), .clk_in_pin(clk_in_pin),
        .clk_in_is_clock(clk_in_is_clock), .clk_out_pin_i(pin_lvl),
        .clk_out_pin_o(clk_out_pin_o), .clk_out_pin_oe(clk_out_pin_oe),
        .port_a_bit4_out(port_a_bit4_out), .port_a_bit4_dir(port_a_bit4_dir),
        .port_a_bit4_in(port_a_bit4_in), .clk_times_four(clk_times_four),
        .clk_times_two(clk_times_two), .internal_osc_clk(internal_osc_clk));

    ocss_ext_src ocss_ext_src_inst (.run(ext_run), .clk_out(clk_in_pin));

    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_range(input string nm, input int lo, input int hi, input int g);
        total_checks++;
        if (g < lo || g > hi) begin
            n_errors++;
            $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask

    // Bounded wait for hready high at a rising edge
    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                n_errors++;
                $display("Error bus wait expected ready seen stuck");
                give_verdict();
            end
            @(posedge hclk);
        end
    endtask

    // Called right after a rising edge; one single word transfer
    task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                            output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        hwrite <= wr;
        htrans <= 2'b10;
        wait_ready();
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        ahb_xfer(1'b1, a, d, dummy);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] g;
        ahb_xfer(1'b0, a, 32'h0000_0000, g);
        chk_val(nm, e, g);
    endtask

    // Rising edges of one clock output, sampled on hclk
    task automatic cnt_rise(input int which, input int n, output int c);
        logic p, s;
        p = 1'b1;
        c = 0;
        repeat (n) begin
            @(posedge hclk);
            case (which)
                0: s = internal_osc_clk;
                1: s = clk_times_four;
                2: s = clk_times_two;
                default: s = clk_out_pin_o;
            endcase
            if (s === 1'b1 && p === 1'b0) c++;
            // Unknown level must not pass as no edges
            if (s !== 1'b0 && s !== 1'b1) c = -100000;
            p = s;
        end
    endtask

    initial begin
        repeat (100000) @(posedge hclk);
        n_errors++;
        $display("Error run length expected end seen hang");
        give_verdict();
    end

    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk("status", `OCSS_STATUS_OFS, S_RUN);
        chk_val("hresp", 32'h0000_0000, hresp);
        rd_chk("trim", `OCSS_TRIM_OFS, {24'h00_0000, `OCSS_TRIM_RST});
        rd_chk("config", `OCSS_CONFIG_OFS, 32'h0000_0000);
        rd_chk("pullup", `OCSS_PULLUP_OFS, 32'h0000_0000);
        rd_chk("unmapped", 8'h10, 32'h0000_0000);
        for (int i = 0; i < 3; i++) begin
            wr(`OCSS_TRIM_OFS, {24'h00_0000, tval[i]});
            rd_chk("trim", `OCSS_TRIM_OFS, {24'h00_0000, tval[i]});
            cnt_rise(0, 1000, cnt);
            chk_range("int_clk", tlo[i], thi[i], cnt);
        end
        wr(`OCSS_TRIM_OFS, 32'h0000_0080);
        cnt_rise(1, 1000, cnt);
        chk_range("x4", 254, 258, cnt);
        cnt_rise(2, 1000, cnt);
        chk_range("x2", 126, 130, cnt);
        wr(`OCSS_PULLUP_OFS, 32'h0000_0001);
        for (int m = 0; m < 4; m++) begin
            wr(`OCSS_CONFIG_OFS, m);
            repeat (4) @(posedge hclk);
            chk_val("in_is_clock", m != 0, clk_in_is_clock);
            chk_val("pin_oe", m != 1, clk_out_pin_oe);
        end
        wr(`OCSS_CONFIG_OFS, 32'h0000_0000);
        cnt_rise(3, 1000, cnt);
        chk_range("pin_x4", 254, 258, cnt);
        wr(`OCSS_PULLUP_OFS, 32'h0000_0000);
        port_a_bit4_dir <= 1'b1;
        port_a_bit4_out <= 1'b1;
        repeat (4) @(posedge hclk);
        chk_val("pin_port", 2'b11, {clk_out_pin_oe, clk_out_pin_o});
        port_a_bit4_dir <= 1'b0;
        sys_osc_enable <= 1'b0;
        repeat (4) @(posedge hclk);
        cnt_rise(1, 200, cnt);
        chk_range("x4_off", 0, 0, cnt);
        sys_osc_enable <= 1'b1;
        stop_mode <= 1'b1;
        repeat (4) @(posedge hclk);
        cnt_rise(1, 200, cnt);
        chk_range("x4_stop", 0, 0, cnt);
        cnt_rise(2, 200, cnt);
        chk_range("x2_stop", 0, 0, cnt);
        stop_mode <= 1'b0;
        ext_run <= 1'b1;
        wr(`OCSS_STATUS_OFS, S_ECG);
        repeat (60) @(posedge hclk);
        rd_chk("status", `OCSS_STATUS_OFS, S_RUN | S_ECG);
        wr(`OCSS_STATUS_OFS, 32'h0000_0000);
        ext_run <= 1'b0;
        wr(`OCSS_CONFIG_OFS, 32'h0000_0001);
        repeat (100) @(posedge hclk);
        wr(`OCSS_STATUS_OFS, S_ECG);
        repeat (60) @(posedge hclk);
        rd_chk("status", `OCSS_STATUS_OFS, S_RUN | S_ECG);
        ext_run <= 1'b1;
        v = 32'h0000_0000;
        k = 0;
        while (v[`OCSS_ENG_BIT] !== 1'b1 && k < 40) begin
            ahb_xfer(1'b0, `OCSS_STATUS_OFS, 32'h0000_0000, v);
            k++;
        end
        chk_val("engaged", 1'b1, v[`OCSS_ENG_BIT]);
        repeat (4) @(posedge hclk);
        rd_chk("status", `OCSS_STATUS_OFS, S_ECG | S_ENG);
        cnt_rise(0, 200, cnt);
        chk_range("int_off", 0, 0, cnt);
        cnt_rise(1, 1300, cnt);
        chk_range("x4_ext", 98, 102, cnt);
        cnt_rise(2, 1300, cnt);
        chk_range("x2_ext", 48, 52, cnt);
        pin_drv <= 1'b1;
        repeat (6) @(posedge hclk);
        chk_val("port_in", 2'b01, {clk_out_pin_oe, port_a_bit4_in});
        ext_run <= 1'b0;
        repeat (100) @(posedge hclk);
        rd_chk("status", `OCSS_STATUS_OFS, S_ECG | S_ENG);
        cnt_rise(0, 200, cnt);
        chk_range("int_off", 0, 0, cnt);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk("status", `OCSS_STATUS_OFS, S_RUN);
        cnt_rise(0, 1000, cnt);
        chk_range("int_clk", 254, 258, cnt);
        give_verdict();
    end
endmodule
`default_nettype wire
